// [rtl/modem_status_and_irq.sv]
// receive status word, sticky interrupt flag and interrupt pin
`timescale 1ns/1ps
module modem_status_and_irq
    import modem_status_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire rx_mode_e    rx_mode,
    input  wire logic [15:0] ctrl_word,
    input  wire logic        ctrl_write,
    input  wire logic        general_reset,
    input  wire logic        status_read,
    input  wire logic        rx_data_read,
    input  wire logic        automodem_read,
    input  wire logic        hdlc_mode,
    input  wire logic        descrambler_on,
    input  wire logic        rx_energy,
    input  wire logic        det_hdlc_flag,
    input  wire logic        det_dotting,
    input  wire logic        det_ones_unscr,
    input  wire logic        det_ones_scr,
    input  wire logic        det_zeros,
    input  wire logic        auto_event,
    input  wire logic        break_detect,
    input  wire logic        rx_data_ready,
    input  wire logic        rx_overflow,
    input  wire logic        framing_error,
    input  wire logic        fcs_error,
    input  wire logic        fcs_last,
    input  wire logic        hdlc_abort,
    input  wire logic        parity_even_first,
    input  wire logic        parity_even_second,
    input  wire logic        two_chars,
    input  wire logic        fsk_demod,
    input  wire logic        fsk_tick,
    input  wire logic        tone_band,
    input  wire logic        tone_first,
    input  wire logic        tone_second,
    input  wire logic        dtmf_burst,
    input  wire logic [1:0]  dtmf_row,
    input  wire logic [1:0]  dtmf_col,
    input  wire logic        ring_detect_low_input,
    output logic [15:0]      status_word,
    output logic             interrupt_request_low_pin
);
    typedef struct packed {
        logic [15:0] st;
        logic        pin;
    } status_state_s;

    status_state_s q;
    status_state_s next_q;
    logic          ring_active;
    logic          modem_mode;
    logic          clear_all;
    logic          irq_clear;
    logic [9:0]    mask_vec;
    logic [9:0]    rise;

    pattern_if pat ();

    ////////////////////////////////////////////////////////////////////////
    // submodules

    ring_sync u_ring (
        .clk_sys              (clk_sys),
        .rst_n                (rst_n),
        .ring_detect_low_input(ring_detect_low_input),
        .ring_active          (ring_active)
    );

    pattern_coder u_pattern (
        .pat(pat.coder)
    );

    // detectors feed the coder unconditionally, energy does not gate them
    assign pat.hdlc_flag      = det_hdlc_flag;
    assign pat.dotting        = det_dotting;
    assign pat.ones_unscr     = det_ones_unscr;
    assign pat.ones_scr       = det_ones_scr;
    assign pat.zeros          = det_zeros;
    assign pat.descrambler_on = descrambler_on;
    assign pat.enhanced       = ctrl_word[CTL_ENHANCED];
    assign pat.v22_mode       = (rx_mode == RX_QAM_MANUAL);

    ////////////////////////////////////////////////////////////////////////
    // mode decode, clear sources and interrupt masks

    assign modem_mode = (rx_mode == RX_FSK) || (rx_mode == RX_QAM_MANUAL)
                        || (rx_mode == RX_QAM_AUTO);
    assign clear_all = general_reset | ctrl_word[CTL_RESET]
                       | ~ctrl_word[CTL_POWERUP];
    // a write that sets reset or power-up also drops the flag
    assign irq_clear = status_read | general_reset
                       | (ctrl_write & (ctrl_word[CTL_RESET] | ctrl_word[CTL_POWERUP]));
    // index 0 is status bit 5; bits 13-11 are never set here
    assign mask_vec = {ctrl_word[CTL_RING_IRQ] & ctrl_word[CTL_PIN_EN],
                       3'h0,
                       ctrl_word[CTL_MASK2],
                       {3{ctrl_word[CTL_MASK1]}},
                       {2{ctrl_word[CTL_MASK0]}}};

    ////////////////////////////////////////////////////////////////////////
    // next status word
    always_comb begin
        next_q        = q;
        next_q.st[13:11] = 3'h0;
        // keeps running under reset bit and power-down
        next_q.st[ST_RING] = ring_active;
        unique case (rx_mode)
            RX_TONES: begin
                next_q.st[ST_B10] = tone_band;
                next_q.st[ST_B9]  = 1'b0;
                next_q.st[ST_B8]  = 1'b0;
                next_q.st[ST_B7]  = tone_second;
                next_q.st[ST_READY] = tone_first;
                // each burst refreshes the key code and raises bit 5
                next_q.st[ST_OVER] = dtmf_burst | (q.st[ST_OVER] & ~status_read);
                next_q.st[ST_ERR]  = 1'b0;
                if (dtmf_burst) begin
                    next_q.st[3:0] = dtmf_encode(dtmf_row, dtmf_col);
                end
            end
            RX_FSK, RX_QAM_MANUAL, RX_QAM_AUTO: begin
                if (rx_mode == RX_QAM_AUTO) begin
                    next_q.st[ST_B10] = 1'b0;
                    // event wins over a read in the same cycle
                    next_q.st[ST_B9] = auto_event | (q.st[ST_B9] & ~automodem_read);
                    next_q.st[ST_B8] = break_detect | (q.st[ST_B8] & ~status_read);
                    next_q.st[ST_B7] = 1'b0;
                end else begin
                    next_q.st[ST_B10]      = rx_energy;
                    next_q.st[ST_B9:ST_B7] = pat.code;
                end
                next_q.st[ST_READY] = rx_data_ready | (q.st[ST_READY] & ~rx_data_read);
                next_q.st[ST_OVER]  = rx_overflow | (q.st[ST_OVER] & ~rx_data_read);
                next_q.st[ST_ERR]   = framing_error | fcs_error
                                      | (q.st[ST_ERR] & ~status_read);
                if (hdlc_mode) begin
                    next_q.st[ST_B3]  = fcs_last | (q.st[ST_B3] & ~status_read);
                    next_q.st[ST_B2]  = hdlc_abort | (q.st[ST_B2] & ~status_read);
                    next_q.st[ST_TWO] = 1'b0;
                end else if (rx_data_ready) begin
                    // parity and count travel with the character
                    next_q.st[ST_B3]  = parity_even_first;
                    next_q.st[ST_B2]  = parity_even_second & two_chars;
                    next_q.st[ST_TWO] = two_chars;
                end
                if (rx_mode != RX_FSK) begin
                    next_q.st[ST_B0] = 1'b0;
                end else if (fsk_tick) begin
                    next_q.st[ST_B0] = fsk_demod;
                end
            end
            default: begin
                next_q.st[10:0] = 11'h000;
            end
        endcase
        if (clear_all) begin
            next_q.st[13:0] = 14'h0000;
        end
        // rises are judged on the bits after any clear
        rise = next_q.st[14:5] & ~q.st[14:5] & mask_vec;
        next_q.st[ST_IRQ] = (|rise) | (q.st[ST_IRQ] & ~irq_clear);
        next_q.pin = ~(next_q.st[ST_IRQ] & ctrl_word[CTL_PIN_EN]);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: STATUS_RESET, pin: PIN_RESET};
        end else begin
            q <= next_q;
        end
    end

    assign status_word               = q.st;
    assign interrupt_request_low_pin = q.pin;

    ////////////////////////////////////////////////////////////////////////
    // checks next to the logic
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    irq_set_a: assert property (
        (modem_mode && rx_data_ready && !status_word[ST_READY] && ctrl_word[CTL_MASK0] && !clear_all)
        |=> status_word[ST_IRQ]
    ) else $error("masked data ready did not raise flag");

    irq_clear_a: assert property (
        (status_read && rise == 10'h000) |=> !status_word[ST_IRQ]
    ) else $error("flag survived a status read");

    pin_level_a: assert property (
        interrupt_request_low_pin == !(status_word[ST_IRQ] && $past(ctrl_word[CTL_PIN_EN]))
    ) else $error("interrupt pin disagrees with flag and enable");

    no_mask_a: assert property (
        (!status_word[ST_IRQ] && ctrl_word[2:0] == 3'h0 && !ctrl_word[CTL_RING_IRQ])
        |=> !status_word[ST_IRQ]
    ) else $error("flag rose with all masks clear");

    ring_follow_a: assert property (
        ##1 status_word[ST_RING] == $past(ring_active)
    ) else $error("ring bit does not follow ring input");

    ready_clear_a: assert property (
        (modem_mode && rx_data_read && !rx_data_ready) |=> !status_word[ST_READY]
    ) else $error("ready bit not cleared by data read");

    auto_zero_a: assert property (
        (rx_mode == RX_QAM_AUTO) |=> (status_word[ST_B10] == 1'b0 && status_word[ST_B7] == 1'b0)
    ) else $error("automodem bits 10 or 7 not zero");

    auto_event_a: assert property (
        (rx_mode == RX_QAM_AUTO && auto_event && !clear_all) |=> status_word[ST_B9]
    ) else $error("automodem event lost");

    clear_all_a: assert property (
        clear_all |=> status_word[13:0] == 14'h0000
    ) else $error("clear source left status bits set");

    scr_ones_a: assert property (
        (rx_mode == RX_QAM_MANUAL && det_ones_unscr && !clear_all)
        |=> status_word[ST_B9:ST_B7] != PAT_ONES_SCR
    ) else $error("scrambled ones shown over unscrambled ones");

    qam_bit0_a: assert property (
        (rx_mode == RX_QAM_MANUAL || rx_mode == RX_QAM_AUTO) |=> !status_word[ST_B0]
    ) else $error("demodulator bit nonzero in QAM mode");

    ////////////////////////////////////////////////////////////////////////
    // set and clear of single bits and of the bit 9-7 pattern code; clear sources are kept out of each antecedent except those of over_clear_a and auto_clear_a

    ready_set_a: assert property (
        (modem_mode && rx_data_ready && !clear_all)
        |=> status_word[ST_READY]
    ) else $error("bit 6 not set");

    over_clear_a: assert property (
        (modem_mode && rx_data_read && !rx_overflow)
        |=> !status_word[ST_OVER]
    ) else $error("bit 5 not cleared");

    err_set_a: assert property (
        (modem_mode && (framing_error || fcs_error) && !clear_all)
        |=> status_word[ST_ERR]
    ) else $error("bit 4 not set");

    hdlc_last_a: assert property (
        (modem_mode && hdlc_mode && fcs_last && !clear_all)
        |=> status_word[ST_B3]
    ) else $error("bit 3 not set");

    hdlc_abort_a: assert property (
        (modem_mode && hdlc_mode && hdlc_abort && !clear_all)
        |=> status_word[ST_B2]
    ) else $error("bit 2 not set");

    parity_first_a: assert property (
        (modem_mode && !hdlc_mode && rx_data_ready && !clear_all)
        |=> status_word[ST_B3] == $past(parity_even_first)
    ) else $error("first parity not loaded");

    two_char_a: assert property (
        (modem_mode && !hdlc_mode && rx_data_ready && !clear_all)
        |=> status_word[ST_TWO] == $past(two_chars)
    ) else $error("character count not loaded");

    fsk_bit0_a: assert property (
        (rx_mode == RX_FSK && fsk_tick && !clear_all)
        |=> status_word[ST_B0] == $past(fsk_demod)
    ) else $error("bit 0 not refreshed");

    auto_clear_a: assert property (
        (rx_mode == RX_QAM_AUTO && automodem_read && !auto_event)
        |=> !status_word[ST_B9]
    ) else $error("bit 9 not cleared");

    break_set_a: assert property (
        (rx_mode == RX_QAM_AUTO && break_detect && !clear_all)
        |=> status_word[ST_B8]
    ) else $error("bit 8 not set");

    irq_hold_a: assert property (
        (status_word[ST_IRQ] && !irq_clear)
        |=> status_word[ST_IRQ]
    ) else $error("flag dropped without a clear");

    dtmf_set_a: assert property (
        (rx_mode == RX_TONES && dtmf_burst && !clear_all)
        |=> status_word[ST_OVER]
    ) else $error("burst did not set bit 5");

    hdlc_code_a: assert property (
        (rx_mode == RX_QAM_MANUAL && ctrl_word[CTL_ENHANCED] && det_hdlc_flag && !clear_all)
        |=> status_word[ST_B9:ST_B7] == PAT_HDLC
    ) else $error("flag pattern not shown");

    legacy_dot_a: assert property (
        ((rx_mode == RX_FSK || rx_mode == RX_QAM_MANUAL) && !ctrl_word[CTL_ENHANCED] && !clear_all)
        |=> status_word[ST_B9] == $past(det_dotting)
    ) else $error("legacy dotting bit lost");
endmodule

// [common/modem_status_pkg.sv]
// constants, types and helpers shared by the receive status and interrupt block
package modem_status_pkg;

    typedef enum logic [2:0] {
        RX_OFF,
        RX_TONES,
        RX_FSK,
        RX_QAM_MANUAL,
        RX_QAM_AUTO
    } rx_mode_e;

    // status word bit positions
    localparam int ST_IRQ   = 15;
    localparam int ST_RING  = 14;
    localparam int ST_B10   = 10;
    localparam int ST_B9    = 9;
    localparam int ST_B8    = 8;
    localparam int ST_B7    = 7;
    localparam int ST_READY = 6;
    localparam int ST_OVER  = 5;
    localparam int ST_ERR   = 4;
    localparam int ST_B3    = 3;
    localparam int ST_B2    = 2;
    localparam int ST_TWO   = 1;
    localparam int ST_B0    = 0;

    // control word bit positions
    localparam int CTL_MASK0    = 0;
    localparam int CTL_MASK1    = 1;
    localparam int CTL_MASK2    = 2;
    localparam int CTL_RING_IRQ = 5;
    localparam int CTL_PIN_EN   = 6;
    localparam int CTL_RESET    = 7;
    localparam int CTL_POWERUP  = 8;
    localparam int CTL_ENHANCED = 13;

    // values after reset
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic        PIN_RESET    = 1'b1;
    localparam logic [1:0]  SYNC_RESET   = 2'h3;

    // pattern codes on bits 9-7
    localparam logic [2:0] PAT_NONE       = 3'h0;
    localparam logic [2:0] PAT_ONES_UNSCR = 3'h1;
    localparam logic [2:0] PAT_ZEROS      = 3'h2;
    localparam logic [2:0] PAT_ONES_SCR   = 3'h3;
    localparam logic [2:0] PAT_DOTTING    = 3'h4;
    localparam logic [2:0] PAT_HDLC       = 3'h7;

    // key code per {row, column}, nibble 0 at the bottom
    localparam logic [63:0] DTMF_CODE_TABLE = 64'h0cabf987e654d321;

    function automatic logic [3:0] dtmf_encode(input logic [1:0] row, input logic [1:0] col);
        logic [3:0] idx;
        idx = {row, col};
        return DTMF_CODE_TABLE[{idx, 2'h0} +: 4];
    endfunction

endpackage

// [common/pattern_if.sv]
// detector flags and formatted pattern code between status block and coder
`timescale 1ns/1ps
interface pattern_if;
    logic       hdlc_flag;
    logic       dotting;
    logic       ones_unscr;
    logic       ones_scr;
    logic       zeros;
    logic       descrambler_on;
    logic       enhanced;
    logic       v22_mode;
    logic [2:0] code;

    modport feed (
        output hdlc_flag,
        output dotting,
        output ones_unscr,
        output ones_scr,
        output zeros,
        output descrambler_on,
        output enhanced,
        output v22_mode,
        input  code
    );

    modport coder (
        input  hdlc_flag,
        input  dotting,
        input  ones_unscr,
        input  ones_scr,
        input  zeros,
        input  descrambler_on,
        input  enhanced,
        input  v22_mode,
        output code
    );
endinterface

// [rtl/pattern_coder.sv]
// formats the receive pattern detector flags into status bits 9-7
`timescale 1ns/1ps
module pattern_coder
    import modem_status_pkg::*;
(
    pattern_if.coder pat
);
    logic ones_scr_ok;
    logic [1:0] legacy_low;

    ////////////////////////////////////////////////////////////////////////
    // priority coding; the coder holds no state of its own
    always_comb begin
        ones_scr_ok = pat.descrambler_on & pat.ones_scr & ~pat.ones_unscr;
        if (pat.ones_unscr) begin
            legacy_low = PAT_ONES_UNSCR[1:0];
        end else if (ones_scr_ok) begin
            legacy_low = PAT_ONES_SCR[1:0];
        end else if (pat.zeros) begin
            legacy_low = PAT_ZEROS[1:0];
        end else begin
            legacy_low = PAT_NONE[1:0];
        end
        // flag detection is only meaningful in the V.22 family
        if (!pat.enhanced) begin
            pat.code = {pat.dotting, legacy_low};
        end else if (pat.hdlc_flag && pat.v22_mode) begin
            pat.code = PAT_HDLC;
        end else if (pat.dotting) begin
            pat.code = PAT_DOTTING;
        end else begin
            pat.code = {1'b0, legacy_low};
        end
    end
endmodule

// [rtl/ring_sync.sv]
// brings the ring detect pin into the system clock and inverts it
`timescale 1ns/1ps
module ring_sync
    import modem_status_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ring_detect_low_input,
    output logic      ring_active
);
    typedef struct packed {
        logic [1:0] sync;
        logic       active;
    } ring_state_s;

    ring_state_s q;
    ring_state_s next_q;

    ////////////////////////////////////////////////////////////////////////
    // stage 0 feeds only stage 1; only stage 1 is decoded
    always_comb begin
        next_q        = q;
        next_q.sync   = {q.sync[0], ring_detect_low_input};
        next_q.active = ~q.sync[1];
    end

    // idle line is high, so reset assumes no ring
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{sync: SYNC_RESET, active: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign ring_active = q.active;
endmodule

// [dv/host_model.sv]
// host side model: control writes and read strobes on the serial control bus
`timescale 1ns/1ps
module host_model
(
    input  wire logic   clk_sys,
    output logic [15:0] ctrl_word,
    output logic        ctrl_write,
    output logic        general_reset,
    output logic        status_read,
    output logic        rx_data_read,
    output logic        automodem_read
);
    localparam int SETTLE_CYCLES = 6000; // 150 us at 25 ns
    logic [3:0] strobes;

    // 0 status read, 1 data read, 2 automodem read, 3 general reset
    assign {general_reset, automodem_read, rx_data_read, status_read} = strobes;

    initial begin
        ctrl_word = 16'h0000;
        ctrl_write = 1'b0;
        strobes = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobe, launched just after an edge
    task automatic strobe(input int idx);
        @(posedge clk_sys);
        #2 strobes[idx] = 1'b1;
        @(posedge clk_sys);
        #2 strobes[idx] = 1'b0;
    endtask

    // control word stays as a level once written
    task automatic write_ctrl(input logic [15:0] value);
        @(posedge clk_sys);
        #2 ctrl_word = value;
        ctrl_write = 1'b1;
        @(posedge clk_sys);
        #2 ctrl_write = 1'b0;
    endtask

    // status is not trusted until a mode change has settled
    task automatic settle();
        repeat (SETTLE_CYCLES) @(posedge clk_sys);
        #2;
    endtask
endmodule

// [dv/modem_status_and_irq_tb.sv]
// self-checking bench for the receive status and interrupt block
`timescale 1ns/1ps
module modem_status_and_irq_tb
    import modem_status_pkg::*;
;
    logic        clk_sys;
    logic        rst_n;
    rx_mode_e    mode;
    logic [9:0]  ev;     // one-cycle event pulses
    logic [6:0]  lv;     // level qualifiers
    logic [4:0]  det;    // hdlc, dotting, unscr, scr, zeros
    logic        descr;
    logic        energy;
    logic        fsk_d;
    logic [1:0]  row;
    logic [1:0]  col;
    logic        ring_n;
    logic [15:0] ctrl;
    logic        ctrl_wr;
    logic        gen_rst;
    logic        st_rd;
    logic        rd_rd;
    logic        am_rd;
    logic [15:0] st;
    logic        irq_n;
    logic [31:0] seed;
    int          err_count;
    int          comparisons;
    int          n;
    int          pidx[4] = '{5, 6, 7, 4};
    int          pbit[4] = '{ST_ERR, ST_B3, ST_B2, ST_ERR};

    host_model host_model_i (.clk_sys(clk_sys), .ctrl_word(ctrl), .ctrl_write(ctrl_wr), .general_reset(gen_rst),
        .status_read(st_rd), .rx_data_read(rd_rd), .automodem_read(am_rd));

    modem_status_and_irq modem_status_and_irq_i (.clk_sys(clk_sys), .rst_n(rst_n), .rx_mode(mode),
        .ctrl_word(ctrl), .ctrl_write(ctrl_wr), .general_reset(gen_rst), .status_read(st_rd),
        .rx_data_read(rd_rd), .automodem_read(am_rd), .hdlc_mode(lv[0]), .descrambler_on(descr),
        .rx_energy(energy), .det_hdlc_flag(det[4]), .det_dotting(det[3]), .det_ones_unscr(det[2]),
        .det_ones_scr(det[1]), .det_zeros(det[0]), .auto_event(ev[0]), .break_detect(ev[1]),
        .rx_data_ready(ev[2]), .rx_overflow(ev[3]), .framing_error(ev[4]), .fcs_error(ev[5]),
        .fcs_last(ev[6]), .hdlc_abort(ev[7]), .parity_even_first(lv[1]), .parity_even_second(lv[2]),
        .two_chars(lv[3]), .fsk_demod(fsk_d), .fsk_tick(ev[8]), .tone_band(lv[4]), .tone_first(lv[5]),
        .tone_second(lv[6]), .dtmf_burst(ev[9]), .dtmf_row(row), .dtmf_col(col),
        .ring_detect_low_input(ring_n), .status_word(st), .interrupt_request_low_pin(irq_n));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // legacy coding only ever sees the descrambler on, where its table is complete
    function automatic logic [2:0] exp_pattern(input logic enh, input logic qam, input logic [4:0] d,
                                               input logic ds);
        logic scr;
        scr = d[1] & ds & !d[2];
        if (!enh) return {d[3], scr | (d[0] & !d[2]), d[2] | scr};
        if (d[4] & qam) return 3'h7;
        if (d[3]) return 3'h4;
        if (d[2]) return 3'h1;
        if (scr) return 3'h3;
        return d[0] ? 3'h2 : 3'h0;
    endfunction

    // key code from row and column frequency index
    function automatic logic [3:0] dtmf_key(input logic [1:0] r, input logic [1:0] c);
        if (c == 2'h3) return (r == 2'h3) ? 4'h0 : 4'hd + {2'h0, r};
        if (r == 2'h3) return (c == 2'h0) ? 4'hb : (c == 2'h1) ? 4'ha : 4'hc;
        return {r, 2'h0} - {2'h0, r} + {2'h0, c} + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t status mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_bit(input int pos, input logic val);
        check({15'h0, st[pos]}, {15'h0, val});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic pulse(input int idx);
        @(posedge clk_sys);
        #2 ev[idx] = 1'b1;
        @(posedge clk_sys);
        #2 ev[idx] = 1'b0;
    endtask

    task automatic wait_cycles(input int cnt);
        repeat (cnt) @(posedge clk_sys);
        #2;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h0000a42b;
        {ev, lv, det, descr, energy, fsk_d, row, col} = '0;
        mode = RX_OFF;
        ring_n = 1'b1;
        err_count = 0;
        comparisons = 0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        #2 rst_n = 1'b1;
        check(st, STATUS_RESET);
        check({15'h0, irq_n}, {15'h0, PIN_RESET});
        // start-stop receive: ready, parity, two characters, flag and pin
        host_model_i.write_ctrl(16'h0141);
        // receiver off: random inputs leave the word quiet
        for (int k = 0; k < 16; k++) begin
            seed = rnd();
            {ev, lv} = seed[16:0];
            wait_cycles(1);
            check(st, 16'h0000);
        end
        {ev, lv} = '0;
        mode = RX_FSK;
        host_model_i.settle();
        lv[3:1] = 3'h7;
        pulse(2);
        check(st, 16'h804e);
        check({15'h0, irq_n}, 16'h0000);
        host_model_i.strobe(0);
        check(st, 16'h004e);
        check({15'h0, irq_n}, 16'h0001);
        host_model_i.strobe(1);
        chk_bit(ST_READY, 1'b0);
        lv[3:1] = 3'h3;
        pulse(2);
        check({13'h0, st[3:1]}, 16'h0004);
        host_model_i.write_ctrl(16'h0140);
        chk_bit(ST_IRQ, 1'b0);
        host_model_i.strobe(1);
        pulse(3);
        chk_bit(ST_OVER, 1'b1);
        chk_bit(ST_IRQ, 1'b0);
        host_model_i.strobe(1);
        chk_bit(ST_OVER, 1'b0);
        fsk_d = 1'b1;
        pulse(8);
        chk_bit(ST_B0, 1'b1);
        $display("start-stop test done");
        // pattern coding, random detector mixes in both manual modes
        for (int m = 0; m < 2; m++) begin
            mode = m ? RX_QAM_MANUAL : RX_FSK;
            host_model_i.settle();
            if (m) chk_bit(ST_B0, 1'b0);
            for (int k = 0; k < 24; k++) begin
                seed = rnd();
                det = seed[5:1];
                descr = seed[0] ? seed[6] : 1'b1;
                energy = seed[7];
                host_model_i.write_ctrl({2'h0, seed[0], 13'h0100});
                wait_cycles(2);
                check({13'h0, st[9:7]}, {13'h0, exp_pattern(seed[0], m[0], det, descr)});
                chk_bit(ST_B10, energy);
            end
        end
        $display("pattern test done");
        // frame errors and hdlc markers, each cleared by a status read
        for (int i = 0; i < 4; i++) begin
            lv[0] = (i < 3);
            pulse(pidx[i]);
            chk_bit(pbit[i], 1'b1);
            host_model_i.strobe(0);
        end
        $display("error flag test done");
        // automodem event and break
        det = 5'h08;
        energy = 1'b1;
        host_model_i.write_ctrl(16'h0102);
        mode = RX_QAM_AUTO;
        host_model_i.settle();
        // dotting left bit 9 set in manual mode; drop it so the event rises
        host_model_i.strobe(2);
        chk_bit(ST_B9, 1'b0);
        pulse(0);
        check({12'h0, st[10:7]}, 16'h0004);
        chk_bit(ST_IRQ, 1'b1);
        host_model_i.strobe(0);
        chk_bit(ST_B9, 1'b1);
        host_model_i.strobe(2);
        chk_bit(ST_B9, 1'b0);
        pulse(1);
        check({12'h0, st[10:7]}, 16'h0002);
        $display("automodem test done");
        // every key of the keypad
        host_model_i.write_ctrl(16'h0141);
        mode = RX_TONES;
        host_model_i.settle();
        for (int i = 0; i < 16; i++) begin
            {row, col} = i[3:0];
            seed = rnd();
            lv[6:4] = seed[2:0];
            pulse(9);
            check({12'h0, st[3:0]}, {12'h0, dtmf_key(row, col)});
            check({14'h0, st[ST_IRQ], st[ST_OVER]}, 16'h0003);
            check({13'h0, st[ST_B10], st[ST_B7], st[ST_READY]}, {13'h0, lv[4], lv[6], lv[5]});
            host_model_i.strobe(0);
        end
        // tone levels idle, so later rises come from bursts and the ring only
        lv = '0;
        host_model_i.write_ctrl(16'h0140);
        pulse(9);
        check({14'h0, st[ST_IRQ], st[ST_OVER]}, 16'h0001);
        $display("tone test done");
        // ring pin toggled off the clock grid, then held active
        host_model_i.write_ctrl(16'h0160);
        #37;
        repeat (3) begin
            ring_n = 1'b0;
            #100 ring_n = 1'b1;
            #100;
        end
        ring_n = 1'b0;
        for (n = 0; n < 10 && st[ST_RING] !== 1'b1; n++) @(posedge clk_sys);
        if (n == 10) begin
            err_count++;
            complete_run();
        end
        wait_cycles(2);
        check({14'h0, st[15:14]}, 16'h0003);
        check({15'h0, irq_n}, 16'h0000);
        host_model_i.write_ctrl(16'h01e0);
        check(st, 16'h4000);
        ring_n = 1'b1;
        host_model_i.write_ctrl(16'h0141);
        ring_n = 1'b0;
        wait_cycles(5);
        check({14'h0, st[15:14]}, 16'h0001);
        pulse(9);
        host_model_i.strobe(3);
        check(st, 16'h4000);
        $display("ring and reset test done");
        complete_run();
    end
endmodule
